// ==== imrb_regs.svh ====
// Register map constants for the instrument register bank.
// Assumes inclusion by the package and the design module only.
`ifndef IMRB_REGS_SVH
`define IMRB_REGS_SVH
// Coil offsets.
`define IMRB_COIL_RESTART_WARN    3'h0
`define IMRB_COIL_PUMP_STANDBY    3'h1
`define IMRB_COIL_SERVICE_CLEAR   3'h2
`define IMRB_COIL_WARN_HOLD       3'h3
`define IMRB_COIL_REBOOT          3'h4
`define IMRB_COIL_COUNT           5
// Discrete input offsets.
`define IMRB_DI_SERVICE_DUE       3'h0
`define IMRB_DI_COUNT             7
// Holding register.
`define IMRB_HR_NODE_ADDR         6'h00
`define IMRB_NODE_ADDR_RST        16'h0001
`define IMRB_NODE_ADDR_MIN        16'h0001
`define IMRB_NODE_ADDR_MAX        16'h00F7
// Input register offsets (16-bit word index, pairs hold one float).
`define IMRB_IR_RESERVOIR_P       6'h00
`define IMRB_IR_OUTLET_P          6'h02
`define IMRB_IR_SCRUB_TEMP        6'h04
`define IMRB_IR_ENCL_TEMP         6'h06
`define IMRB_IR_COMP_DUTY         6'h08
`define IMRB_IR_HEAT_DUTY         6'h0A
`define IMRB_IR_HOURS_LEFT        6'h0C
`define IMRB_IR_REF_MV            6'h0E
`define IMRB_IR_MODEL             6'h1E
`define IMRB_IR_UNIT_ID           6'h20
`define IMRB_IR_FW_PART           6'h22
`define IMRB_IR_FW_REV            6'h24
// Timing.
`define IMRB_CLK_HZ               200000000
`define IMRB_SECONDS_PER_HOUR     3600
`define IMRB_HOUR_CYCLES          (`IMRB_CLK_HZ * 64'd`IMRB_SECONDS_PER_HOUR)
`define IMRB_SERVICE_HOURS        16'd2000
`define IMRB_WARMUP_SECONDS       1800
`define IMRB_WARMUP_CYCLES        (`IMRB_CLK_HZ * 64'd`IMRB_WARMUP_SECONDS)
`define IMRB_BAUD_DEFAULT         57600
`define IMRB_DATA_BITS            8
`define IMRB_STOP_BITS            1
`endif

// ==== imrb_pkg.sv ====
// Types shared by the instrument register bank.
// Assumes imrb_regs.svh sits in the same folder.
`include "imrb_regs.svh"
package imrb_pkg;
    // Access spaces of the register protocol.
    typedef enum logic [1:0] {
        IMRB_SP_COIL    = 2'b00,
        IMRB_SP_DISC    = 2'b01,
        IMRB_SP_HOLD    = 2'b10,
        IMRB_SP_INPUT   = 2'b11
    } imrb_space_type;
    typedef struct packed {
        logic           rd;
        logic           wr;
        imrb_space_type space;
        logic [5:0]     addr;
        logic [15:0]    wdata;
    } imrb_req_type;
    typedef struct packed {
        logic        valid;
        logic        err;
        logic [15:0] rdata;
    } imrb_rsp_type;
    // Measured floats supplied by acquisition, each IEEE 754 single.
    typedef struct packed {
        logic [31:0] reservoir_p;
        logic [31:0] outlet_p;
        logic [31:0] scrub_temp;
        logic [31:0] encl_temp;
        logic [31:0] comp_duty;
        logic [31:0] heat_duty;
        logic [31:0] ref_mv;
        logic [31:0] model;
        logic [31:0] unit_id;
        logic [31:0] fw_part;
        logic [31:0] fw_rev;
    } imrb_meas_type;
    // Warning inputs from the instrument, discrete inputs 1 to 6.
    typedef struct packed {
        logic servicing;
        logic encl_shutdown;
        logic moist_shutdown;
        logic outlet_low;
        logic scrub_heat;
        logic moisture;
    } imrb_alarm_type;
    typedef enum logic [1:0] {
        IMRB_ST_WARMUP = 2'b00,
        IMRB_ST_RUN    = 2'b01,
        IMRB_ST_REBOOT = 2'b10
    } imrb_state_type;
    typedef struct packed {
        imrb_state_type state;
        logic [63:0]    warm_cnt;
        logic [63:0]    hour_cnt;
        logic [15:0]    hours_left;
        logic           restart_warn;
        logic           pump_standby;
        logic           warn_hold;
        logic           service_due;
        logic [15:0]    node_addr;
        logic           reboot_req;
        imrb_alarm_type alarm_s1;
        imrb_alarm_type alarm_s2;
        imrb_alarm_type alarm_s3;
        imrb_alarm_type alarm_q;
        imrb_rsp_type   rsp;
        logic [31:0]    hours_float;
    } imrb_st_type;
endpackage

// ==== imrb_bank.sv ====
// Register bank of the zero-air generator seen by a remote protocol master.
// Assumes a protocol front end that presents one decoded request per cycle
// and acquisition logic that supplies measured floats on the same clock.
//
// Contract
// - Restart sets restart warning coil to one.
// - Written zero or warm-up end clears warning.
// - Hold coil set blocks automatic warm-up clear.
// - Standby coil one stops pump, heater runs.
// - Standby coil zero restores pump operation.
// - Service timer counts hours, reported as float.
// - Countdown end raises service due flag.
// - Clear coil one resets flag, restarts countdown.
// - Node address defaults one, accepts 1..247.
// - New node address takes effect immediately.
// - Measurements are read-only 32-bit float pairs.
// - Serial default 57600 baud, 8E1.
`timescale 1ns/1ps
`include "imrb_regs.svh"
module imrb_bank #(
    parameter logic [63:0] WARMUP_CYCLES = `IMRB_WARMUP_CYCLES,
    parameter logic [63:0] HOUR_CYCLES   = `IMRB_HOUR_CYCLES
) (
    input  wire logic                   ref_clk,
    input  wire logic                   sys_rst,
    input  wire imrb_pkg::imrb_req_type req,
    input  wire imrb_pkg::imrb_meas_type meas,
    input  wire logic [5:0]             alarm_pins,
    output logic [15:0]                 node_addr,
    output logic                        pump_run,
    output logic                        heater_run,
    output logic                        reboot_req,
    output imrb_pkg::imrb_rsp_type      rsp
);
    import imrb_pkg::*;

    imrb_st_type r_r;
    imrb_st_type r_nxt;

    // ****************************************************************
    // Hours remaining as an IEEE 754 single.
    // ****************************************************************
    function automatic logic [31:0] to_float(input logic [15:0] v);
        logic [31:0] f;
        logic [4:0]  msb;
        logic [15:0] norm;
        f    = 32'h0000_0000;
        msb  = 5'h00;
        norm = 16'h0000;
        for (int i = 0; i < 16; i++) begin
            if (v[i]) begin
                msb = 5'(i);
            end
        end
        if (v != 16'h0000) begin
            norm = v << (5'd15 - msb);
            f    = {1'b0, 8'(8'd127 + 8'(msb)), norm[14:0], 8'h00};
        end
        return f;
    endfunction

    function automatic logic [15:0] pick(input logic [31:0] w, input logic lo);
        return lo ? w[15:0] : w[31:16];
    endfunction

    // ****************************************************************
    // Next-state logic.
    // ****************************************************************
    always_comb begin
        logic [15:0] rd;
        logic        err;
        logic        wr_coil;
        logic        wr_hold;
        rd      = 16'h0000;
        err     = 1'b0;
        r_nxt   = r_r;
        // Coil writes beyond the map are refused whole; the low address bits alone would alias.
        wr_coil = req.wr && (req.space == IMRB_SP_COIL) && (req.addr < 6'(`IMRB_COIL_COUNT));
        wr_hold = req.wr && (req.space == IMRB_SP_HOLD);

        // Alarm pins are asynchronous to ref_clk. Only the second stage reads the first,
        // and a new level is taken once the second and third stages agree.
        r_nxt.alarm_s1 = imrb_alarm_type'(alarm_pins);
        r_nxt.alarm_s2 = r_r.alarm_s1;
        r_nxt.alarm_s3 = r_r.alarm_s2;
        if (r_r.alarm_s2 == r_r.alarm_s3) begin
            r_nxt.alarm_q = r_r.alarm_s3;
        end

        unique case (r_r.state)
            IMRB_ST_WARMUP: begin
                if (r_r.warm_cnt >= WARMUP_CYCLES - 64'd1) begin
                    r_nxt.state = IMRB_ST_RUN;
                    if (!r_r.warn_hold) begin
                        r_nxt.restart_warn = 1'b0;
                    end
                end else begin
                    r_nxt.warm_cnt = r_r.warm_cnt + 64'd1;
                end
            end
            IMRB_ST_RUN: begin
            end
            IMRB_ST_REBOOT: begin
                r_nxt.state        = IMRB_ST_WARMUP;
                r_nxt.warm_cnt     = 64'd0;
                r_nxt.restart_warn = 1'b1;
                r_nxt.reboot_req   = 1'b0;
            end
            default: begin
                r_nxt.state = IMRB_ST_WARMUP;
            end
        endcase

        // Service countdown runs only while the standby coil is clear.
        if (!r_r.pump_standby && r_r.hours_left != 16'h0000) begin
            if (r_r.hour_cnt >= HOUR_CYCLES - 64'd1) begin
                r_nxt.hour_cnt   = 64'd0;
                r_nxt.hours_left = r_r.hours_left - 16'd1;
            end else begin
                r_nxt.hour_cnt = r_r.hour_cnt + 64'd1;
            end
        end
        if (r_r.hours_left == 16'h0000) begin
            r_nxt.service_due = 1'b1;
        end
        r_nxt.hours_float = to_float(r_r.hours_left);

        if (wr_coil) begin
            unique case (req.addr[2:0])
                `IMRB_COIL_RESTART_WARN: begin
                    // The restart cycle sets the warning; that set wins over a clear in the same cycle.
                    if (!req.wdata[0] && r_r.state != IMRB_ST_REBOOT) begin
                        r_nxt.restart_warn = 1'b0;
                    end
                end
                `IMRB_COIL_PUMP_STANDBY: r_nxt.pump_standby = req.wdata[0];
                `IMRB_COIL_SERVICE_CLEAR: begin
                    if (req.wdata[0]) begin
                        r_nxt.service_due = 1'b0;
                        r_nxt.hours_left  = `IMRB_SERVICE_HOURS;
                        r_nxt.hour_cnt    = 64'd0;
                    end
                end
                `IMRB_COIL_WARN_HOLD: r_nxt.warn_hold = req.wdata[0];
                `IMRB_COIL_REBOOT: begin
                    if (req.wdata[0]) begin
                        r_nxt.state      = IMRB_ST_REBOOT;
                        r_nxt.reboot_req = 1'b1;
                    end
                end
                default: err = 1'b1;
            endcase
        end
        if (req.wr && (req.space == IMRB_SP_COIL) && !wr_coil) begin
            err = 1'b1;
        end
        if (wr_hold) begin
            if (req.addr != `IMRB_HR_NODE_ADDR) begin
                err = 1'b1;
            end else if (req.wdata >= `IMRB_NODE_ADDR_MIN && req.wdata <= `IMRB_NODE_ADDR_MAX) begin
                r_nxt.node_addr = req.wdata;
            end else begin
                err = 1'b1;
            end
        end
        if (req.wr && (req.space == IMRB_SP_DISC || req.space == IMRB_SP_INPUT)) begin
            err = 1'b1;
        end

        if (req.rd) begin
            unique case (req.space)
                IMRB_SP_COIL: begin
                    if (req.addr < 6'(`IMRB_COIL_COUNT)) begin
                        rd = {11'h000, 1'b0, r_r.warn_hold, 1'b0, r_r.pump_standby, r_r.restart_warn} >>
                             req.addr[2:0];
                        rd = {15'h0000, rd[0]};
                    end else begin
                        err = 1'b1;
                    end
                end
                IMRB_SP_DISC: begin
                    if (req.addr < 6'(`IMRB_DI_COUNT)) begin
                        rd = {9'h000, r_r.alarm_q, r_r.service_due} >> req.addr[2:0];
                        rd = {15'h0000, rd[0]};
                    end else begin
                        err = 1'b1;
                    end
                end
                IMRB_SP_HOLD: begin
                    if (req.addr == `IMRB_HR_NODE_ADDR) begin
                        rd = r_r.node_addr;
                    end else begin
                        err = 1'b1;
                    end
                end
                IMRB_SP_INPUT: begin
                    // High word at the even address, low word at the odd one.
                    unique case ({req.addr[5:1], 1'b0})
                        `IMRB_IR_RESERVOIR_P: rd = pick(meas.reservoir_p, req.addr[0]);
                        `IMRB_IR_OUTLET_P:    rd = pick(meas.outlet_p, req.addr[0]);
                        `IMRB_IR_SCRUB_TEMP:  rd = pick(meas.scrub_temp, req.addr[0]);
                        `IMRB_IR_ENCL_TEMP:   rd = pick(meas.encl_temp, req.addr[0]);
                        `IMRB_IR_COMP_DUTY:   rd = pick(meas.comp_duty, req.addr[0]);
                        `IMRB_IR_HEAT_DUTY:   rd = pick(meas.heat_duty, req.addr[0]);
                        `IMRB_IR_HOURS_LEFT:  rd = pick(r_r.hours_float, req.addr[0]);
                        `IMRB_IR_REF_MV:      rd = pick(meas.ref_mv, req.addr[0]);
                        `IMRB_IR_MODEL:       rd = pick(meas.model, req.addr[0]);
                        `IMRB_IR_UNIT_ID:     rd = pick(meas.unit_id, req.addr[0]);
                        `IMRB_IR_FW_PART:     rd = pick(meas.fw_part, req.addr[0]);
                        `IMRB_IR_FW_REV:      rd = pick(meas.fw_rev, req.addr[0]);
                        default:              err = 1'b1;
                    endcase
                end
                default: err = 1'b1;
            endcase
        end
        r_nxt.rsp.valid = req.rd || req.wr;
        r_nxt.rsp.err   = err;
        r_nxt.rsp.rdata = rd;
    end

    // ****************************************************************
    // State register.
    // ****************************************************************
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            r_r              <= '0;
            r_r.state        <= IMRB_ST_WARMUP;
            r_r.restart_warn <= 1'b1;
            r_r.node_addr    <= `IMRB_NODE_ADDR_RST;
            r_r.hours_left   <= `IMRB_SERVICE_HOURS;
        end else begin
            r_r <= r_nxt;
        end
    end

    // Pump stops in standby while the heater keeps the scrubber warm.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pump_run   <= 1'b0;
            heater_run <= 1'b0;
        end else begin
            pump_run   <= !r_nxt.pump_standby && r_nxt.state != IMRB_ST_REBOOT;
            heater_run <= r_nxt.state != IMRB_ST_REBOOT;
        end
    end

    assign node_addr  = r_r.node_addr;
    assign reboot_req = r_r.reboot_req;
    assign rsp        = r_r.rsp;

    // ****************************************************************
    // Checks.
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    function automatic logic wr_zero();
        return req.wr && req.space == IMRB_SP_COIL && req.addr == 6'h00 && !req.wdata[0];
    endfunction
    function automatic logic clr_due();
        return req.wr && req.space == IMRB_SP_COIL && req.addr == 6'h02 && req.wdata[0];
    endfunction

    restart_sets_warn_a: assert property (r_r.state == IMRB_ST_REBOOT |=> r_r.restart_warn)
        else $error("restart warning not set after restart");
    zero_clears_warn_a: assert property (req.wr && req.space == IMRB_SP_COIL && req.addr == 6'h00 &&
            !req.wdata[0] && r_r.state != IMRB_ST_REBOOT |=> !r_r.restart_warn)
        else $error("written zero did not clear warning");
    hold_keeps_warn_a: assert property (r_r.warn_hold && r_r.restart_warn && !wr_zero() |=> r_r.restart_warn)
        else $error("held warning cleared by itself");
    standby_stops_pump_a: assert property (r_r.pump_standby && r_r.state != IMRB_ST_REBOOT |-> !pump_run && heater_run)
        else $error("pump running in standby");
    run_restores_pump_a: assert property (!r_nxt.pump_standby && r_nxt.state != IMRB_ST_REBOOT |=> pump_run)
        else $error("pump not restored");
    due_at_zero_a: assert property (r_r.hours_left == 16'h0000 && !clr_due() |=> r_r.service_due)
        else $error("service due not raised");
    clear_restarts_a: assert property (clr_due() |=> !r_r.service_due ##0 r_r.hours_left == `IMRB_SERVICE_HOURS)
        else $error("service clear failed");
    addr_range_a: assert property (r_r.node_addr >= 16'h0001 && r_r.node_addr <= 16'h00F7)
        else $error("node address out of range");
    addr_now_a: assert property (req.wr && req.space == IMRB_SP_HOLD && req.addr == 6'h00 && req.wdata >= 16'h0001 &&
            req.wdata <= 16'h00F7 |=> node_addr == $past(req.wdata))
        else $error("node address not applied");
    ro_ignored_a: assert property (req.wr && req.space == IMRB_SP_INPUT |=> rsp.valid && rsp.err)
        else $error("input register write accepted");
    coil_alias_a: assert property (req.wr && req.space == IMRB_SP_COIL && req.addr >= 6'h05 |=>
            rsp.err && $stable(r_r.pump_standby) && $stable(r_r.warn_hold))
        else $error("coil write beyond map changed state");
    bad_addr_kept_a: assert property (req.wr && req.space == IMRB_SP_HOLD && (req.wdata == 16'h0000 ||
            req.wdata > 16'h00F7) |=> rsp.err && $stable(node_addr))
        else $error("illegal node address applied");
    reboot_pulse_a: assert property (reboot_req && !(req.wr && req.space == IMRB_SP_COIL && req.addr == 6'h04)
            |=> !reboot_req && r_r.restart_warn)
        else $error("reboot request not a single pulse");

    standby_cover_c: cover property (r_r.pump_standby ##1 !r_r.pump_standby);
    due_cover_c: cover property (r_r.service_due ##1 !r_r.service_due);
    reboot_cover_c: cover property (r_r.state == IMRB_ST_REBOOT ##1 r_r.state == IMRB_ST_WARMUP);
    warm_end_c: cover property (r_r.state == IMRB_ST_WARMUP ##1 r_r.state == IMRB_ST_RUN);
endmodule

// ==== imrb_master_model.sv ====
// Behavioural model of the remote protocol master that drives the bank's request port.
// Assumes the bank answers each request with a one-cycle rsp.valid pulse.
`timescale 1ns/1ps
module imrb_master_model (
    input  wire logic                   ref_clk,
    input  wire imrb_pkg::imrb_rsp_type rsp,
    output imrb_pkg::imrb_req_type      req
);
    import imrb_pkg::*;

    initial req = '0;

    // ****************************************
    // Transfer task
    // ****************************************
    // Between requests the qualifiers carry the inverse of the last request, so a
    // bank that samples them outside the strobe cycle sees garbage, not a stale copy.
    task automatic xfer(input logic r, input logic w, input imrb_space_type sp, input logic [5:0] a,
                        input logic [15:0] d, output logic [15:0] rdat, output logic er, output logic to);
        int n;
        to = 1'b1;
        rdat = '0;
        er = 1'b0;
        @(negedge ref_clk);
        req = '{rd: r, wr: w, space: sp, addr: a, wdata: d};
        @(negedge ref_clk);
        req = '{rd: 1'b0, wr: 1'b0, space: imrb_space_type'(~sp), addr: ~a, wdata: ~d};
        for (n = 0; n < 4 && to; n++) begin
            if (rsp.valid === 1'b1) begin
                rdat = rsp.rdata;
                er = rsp.err;
                to = 1'b0;
            end else begin
                @(negedge ref_clk);
            end
        end
    endtask

    // Over a network link the master leaves the node address at one.
    task automatic park_address(output logic [15:0] rdat, output logic er, output logic to);
        xfer(1'b0, 1'b1, IMRB_SP_HOLD, 6'h00, 16'h0001, rdat, er, to);
    endtask
endmodule

// ==== testbench.sv ====
// Self-checking bench for the instrument register bank.
// Assumes the shortened warm-up of 20 cycles and hour of 10 cycles set below.
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
    $display("BAD t=%0t got %h exp %h", $time, (g), (e)); end end
module testbench;
    import imrb_pkg::*;

    logic           ref_clk;
    logic           sys_rst;
    imrb_req_type   req;
    imrb_meas_type  meas;
    logic [5:0]     alarm_pins;
    logic [15:0]    node_addr;
    logic           pump_run;
    logic           heater_run;
    logic           reboot_req;
    imrb_rsp_type   rsp;
    logic [15:0]    rv;
    logic           re;
    logic [31:0]    fv [11];
    int             n_mismatch;
    int             compares;
    int             n_reboot;
    int             i;
    int             k;
    localparam logic [5:0] FADDR [11] = '{6'h00, 6'h02, 6'h04, 6'h06, 6'h08, 6'h0A,
                                          6'h0E, 6'h1E, 6'h20, 6'h22, 6'h24};

    imrb_bank #(.WARMUP_CYCLES(64'd20), .HOUR_CYCLES(64'd10)) DUT (
        .ref_clk    (ref_clk),
        .sys_rst    (sys_rst),
        .req        (req),
        .meas       (meas),
        .alarm_pins (alarm_pins),
        .node_addr  (node_addr),
        .pump_run   (pump_run),
        .heater_run (heater_run),
        .reboot_req (reboot_req),
        .rsp        (rsp)
    );

    imrb_master_model master (
        .ref_clk (ref_clk),
        .rsp     (rsp),
        .req     (req)
    );

    always #2.5 ref_clk = ~ref_clk;

    always @(negedge ref_clk) begin
        if (reboot_req === 1'b1) begin
            n_reboot++;
        end
    end

    // ****************************************
    // Access tasks
    // ****************************************
    task automatic final_report();
        $display("checks %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic acc(input logic r, input logic w, input imrb_space_type sp, input logic [5:0] a,
                       input logic [15:0] d);
        logic to;
        master.xfer(r, w, sp, a, d, rv, re, to);
        if (to) begin
            n_mismatch++;
            $display("BAD t=%0t no response", $time);
            final_report();
        end
    endtask

    task automatic rd(input imrb_space_type sp, input logic [5:0] a);
        acc(1'b1, 1'b0, sp, a, 16'h0000);
    endtask

    task automatic wr(input imrb_space_type sp, input logic [5:0] a, input logic [15:0] d);
        acc(1'b0, 1'b1, sp, a, d);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        ref_clk = 1'b0;
        sys_rst = 1'b1;
        alarm_pins = 6'h00;
        n_mismatch = 0;
        compares = 0;
        n_reboot = 0;
        for (i = 0; i < 11; i++) begin
            fv[i] = {16'hA000 + 16'(i), 16'h5000 + 16'(i)};
            meas[32*(10-i) +: 32] = fv[i];
        end
        repeat (16) @(negedge ref_clk);
        sys_rst = 1'b0;

        rd(IMRB_SP_COIL, 6'h00);
        `CHK(rv[0], 1'b1)
        rd(IMRB_SP_HOLD, 6'h00);
        `CHK(rv, 16'h0001)
        rd(IMRB_SP_INPUT, 6'h0C);
        `CHK(rv, 16'h44FA)
        rd(IMRB_SP_INPUT, 6'h0D);
        `CHK(rv, 16'h0000)
        repeat (40) @(negedge ref_clk);
        rd(IMRB_SP_COIL, 6'h00);
        `CHK(rv[0], 1'b0)
        $display("test reset_and_warmup done");

        for (i = 0; i < 11; i++) begin
            wr(IMRB_SP_INPUT, FADDR[i], 16'h1234);
            `CHK(re, 1'b1)
            rd(IMRB_SP_INPUT, FADDR[i]);
            `CHK(rv, fv[i][31:16])
            rd(IMRB_SP_INPUT, FADDR[i] + 6'h01);
            `CHK(rv, fv[i][15:0])
        end
        rd(IMRB_SP_INPUT, 6'h3F);
        `CHK(re, 1'b1)
        `CHK(rv, 16'h0000)
        wr(IMRB_SP_DISC, 6'h00, 16'h0001);
        `CHK(re, 1'b1)
        $display("test measurements done");

        for (k = 0; k < 2; k++) begin
            alarm_pins = (k == 0) ? 6'h2A : 6'h15;
            repeat (6) @(negedge ref_clk);
            for (i = 1; i < 7; i++) begin
                rd(IMRB_SP_DISC, 6'(i));
                `CHK(rv[0], alarm_pins[i-1])
            end
        end
        $display("test alarms done");

        wr(IMRB_SP_HOLD, 6'h00, 16'h0000);
        `CHK(re, 1'b1)
        wr(IMRB_SP_HOLD, 6'h00, 16'h00F8);
        `CHK(re, 1'b1)
        `CHK(node_addr, 16'h0001)
        wr(IMRB_SP_HOLD, 6'h00, 16'h00F7);
        `CHK(re, 1'b0)
        `CHK(node_addr, 16'h00F7)
        $display("test node_address done");

        wr(IMRB_SP_COIL, 6'h01, 16'h0001);
        @(negedge ref_clk);
        `CHK(pump_run, 1'b0)
        `CHK(heater_run, 1'b1)
        rd(IMRB_SP_COIL, 6'h01);
        `CHK(rv[0], 1'b1)
        wr(IMRB_SP_COIL, 6'h01, 16'h0000);
        @(negedge ref_clk);
        `CHK(pump_run, 1'b1)
        wr(IMRB_SP_COIL, 6'h09, 16'h0001);
        `CHK(re, 1'b1)
        @(negedge ref_clk);
        `CHK(pump_run, 1'b1)
        rd(IMRB_SP_COIL, 6'h01);
        `CHK(rv[0], 1'b0)
        $display("test standby done");

        wr(IMRB_SP_COIL, 6'h03, 16'h0001);
        wr(IMRB_SP_COIL, 6'h04, 16'h0001);
        repeat (3) @(negedge ref_clk);
        `CHK(n_reboot, 1)
        rd(IMRB_SP_COIL, 6'h00);
        `CHK(rv[0], 1'b1)
        repeat (40) @(negedge ref_clk);
        rd(IMRB_SP_COIL, 6'h00);
        `CHK(rv[0], 1'b1)
        `CHK(node_addr, 16'h00F7)
        wr(IMRB_SP_COIL, 6'h00, 16'h0000);
        rd(IMRB_SP_COIL, 6'h00);
        `CHK(rv[0], 1'b0)
        wr(IMRB_SP_COIL, 6'h03, 16'h0000);
        $display("test reboot_hold done");

        rv = '0;
        for (i = 0; i < 300 && rv[0] !== 1'b1; i++) begin
            repeat (100) @(negedge ref_clk);
            rd(IMRB_SP_DISC, 6'h00);
        end
        `CHK(rv[0], 1'b1)
        if (rv[0] !== 1'b1) begin
            final_report();
        end
        rd(IMRB_SP_INPUT, 6'h0C);
        `CHK(rv, 16'h0000)
        wr(IMRB_SP_COIL, 6'h02, 16'h0001);
        rd(IMRB_SP_DISC, 6'h00);
        `CHK(rv[0], 1'b0)
        rd(IMRB_SP_INPUT, 6'h0C);
        `CHK(rv, 16'h44FA)
        rd(IMRB_SP_COIL, 6'h02);
        `CHK(rv[0], 1'b0)
        $display("test service_timer done");

        acc(1'b0, 1'b1, IMRB_SP_HOLD, 6'h00, 16'h0001);
        `CHK(node_addr, 16'h0001)
        final_report();
    end
endmodule
